//--- design/pwtb_regs.svh
// Register map, field positions, reset values and counts of the PWM time-base unit
`ifndef PWTB_REGS_SVH
`define PWTB_REGS_SVH
`define PWTB_IDX_CTRL 4'h0
`define PWTB_IDX_STAT 4'h2
`define PWTB_IDX_FINE 4'h4
`define PWTB_IDX_PHASE 4'h6
`define PWTB_IDX_COUNT 4'h8
`define PWTB_IDX_PERIOD 4'hA
`define PWTB_CTRL_RESET 16'h0083
`define PWTB_STAT_RESET 16'h0001
`define PWTB_F_EMU_HI 15
`define PWTB_F_EMU_LO 14
`define PWTB_F_PSDIR 13
`define PWTB_F_LSP_HI 12
`define PWTB_F_LSP_LO 10
`define PWTB_F_HSP_HI 9
`define PWTB_F_HSP_LO 7
`define PWTB_F_SWSYNC 6
`define PWTB_F_SOSEL_HI 5
`define PWTB_F_SOSEL_LO 4
`define PWTB_F_PERIOD_LOAD_SELECT 3
`define PWTB_F_PHASE_LOAD_ENABLE 2
`define PWTB_F_MODE_HI 1
`define PWTB_F_MODE_LO 0
`define PWTB_S_MAX 2
`define PWTB_S_SYNC 1
`define PWTB_S_DIR 0
`define PWTB_MAX_COUNT 16'hFFFF
`endif

//--- design/pwtb_pkg.sv
// Types of the PWM time-base unit
package pwtb_pkg;
	typedef enum logic [3:0] {
		PWTB_UP = 4'h1,
		PWTB_DOWN = 4'h2,
		PWTB_UPDOWN = 4'h4,
		PWTB_FREEZE = 4'h8
	} pwtb_mode_t;
	typedef enum logic [1:0] {
		PWTB_SO_SYNCIN = 2'h0,
		PWTB_SO_ZERO = 2'h1,
		PWTB_SO_COMPARE_B_VALUE = 2'h2,
		PWTB_SO_OFF = 2'h3
	} pwtb_sosel_t;
endpackage : pwtb_pkg

//--- design/pwtb_top.sv
// PWM time-base unit: prescaler, 16-bit counter, sync, period shadow, APB registers
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "pwtb_regs.svh"
module pwtb_top import pwtb_pkg::*; #(
	parameter int CNT_W = 16,
	parameter bit HAS_FINE = 1'b0
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sync chain and neighbours
	input wire logic sync_in,
	input wire logic emu_halt,
	input wire logic [15:0] compare_b_value,
	output logic sync_out,
	output logic ctr_zero_evt,
	output logic ctr_prd_evt,
	output logic [15:0] count_out
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (CNT_W != 16) begin : g_bad_width
		$error("pwtb_top supports only a 16-bit counter");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	logic [15:0] ctrl_q;
	logic [15:0] phase_q;
	logic [15:0] fine_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] prd_act_q;
	logic [15:0] prd_shd_q;
	logic dir_q;
	logic dir_d;
	logic max_q;
	logic sync_seen_q;
	logic [10:0] pre_q;
	logic halt_stop_q;
	logic sync_s1_q;
	logic sync_s2_q;
	logic sync_s3_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic sync_out_q;
	logic zero_q;
	logic prd_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	wire acc = psel & penable;
	wire wr = acc & pready_q & pwrite;
	wire [3:0] idx = paddr[5:2];
	wire aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
	wire hit_ctrl = aligned && (idx == `PWTB_IDX_CTRL);
	wire hit_stat = aligned && (idx == `PWTB_IDX_STAT);
	wire hit_fine = aligned && (idx == `PWTB_IDX_FINE) && HAS_FINE;
	wire hit_phase = aligned && (idx == `PWTB_IDX_PHASE);
	wire hit_count = aligned && (idx == `PWTB_IDX_COUNT);
	wire hit_prd = aligned && (idx == `PWTB_IDX_PERIOD);
	wire mapped = hit_ctrl | hit_stat | hit_fine | hit_phase | hit_count | hit_prd;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_stat = wr & hit_stat;
	wire wr_cnt = wr & hit_count;
	wire wr_prd = wr & hit_prd;

	////////////////////////////////////////////////////////////////////////
	// Control fields
	wire [1:0] emu = ctrl_q[`PWTB_F_EMU_HI:`PWTB_F_EMU_LO];
	wire post_sync_direction = ctrl_q[`PWTB_F_PSDIR];
	wire [2:0] low_speed_prescale = ctrl_q[`PWTB_F_LSP_HI:`PWTB_F_LSP_LO];
	wire [2:0] high_speed_prescale = ctrl_q[`PWTB_F_HSP_HI:`PWTB_F_HSP_LO];
	wire [1:0] sync_out_source = ctrl_q[`PWTB_F_SOSEL_HI:`PWTB_F_SOSEL_LO];
	wire period_load_select = ctrl_q[`PWTB_F_PERIOD_LOAD_SELECT];
	wire phase_load_enable = ctrl_q[`PWTB_F_PHASE_LOAD_ENABLE];
	wire [1:0] count_mode = ctrl_q[`PWTB_F_MODE_HI:`PWTB_F_MODE_LO];
	pwtb_mode_t mode;
	always_comb begin
		case (count_mode)
			2'h0: mode = PWTB_UP;
			2'h1: mode = PWTB_DOWN;
			2'h2: mode = PWTB_UPDOWN;
			default: mode = PWTB_FREEZE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler: divide = 2^low * (high ? 2*high : 1)
	wire [3:0] hs_div = (high_speed_prescale == 3'h0) ? 4'h1 : {high_speed_prescale, 1'b0};
	wire [10:0] div_w = 11'({7'h0, hs_div} << low_speed_prescale);
	wire tick = (pre_q >= div_w - 11'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 11'h0;
		end else begin
			pre_q <= tick ? 11'h0 : pre_q + 11'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync input: two-flop synchroniser, then edge detect on the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
			sync_s3_q <= 1'b0;
		end else begin
			sync_s1_q <= sync_in;
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
		end
	end
	wire ext_sync = sync_s2_q & ~sync_s3_q;
	wire sw_sync = wr_ctrl & pwdata[`PWTB_F_SWSYNC];
	wire sw_sync_eff = sw_sync & (sync_out_source == PWTB_SO_SYNCIN);
	wire sync_evt = ext_sync | sw_sync_eff;
	wire sync_ld = sync_evt & phase_load_enable;

	////////////////////////////////////////////////////////////////////////
	// Debug halt: hold the counter once the chosen stop point is met
	wire at_prd = (cnt_q == prd_act_q);
	wire at_zero = (cnt_q == 16'h0);
	wire cycle_end = (mode == PWTB_UP) ? at_prd : at_zero;
	// Code 1 holds the count on the stop value itself, not one step past it
	wire halt_at_end = emu_halt & (emu == 2'h1) & cycle_end;
	wire run = ~halt_stop_q & ~halt_at_end & (mode != PWTB_FREEZE);
	wire step = tick & run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_stop_q <= 1'b0;
		end else if (!emu_halt || emu[1]) begin
			halt_stop_q <= 1'b0;
		end else if (emu == 2'h0) begin
			halt_stop_q <= halt_stop_q | step;
		end else begin
			halt_stop_q <= halt_stop_q | cycle_end;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter next value: write beats sync load beats counting
	always_comb begin
		cnt_d = cnt_q;
		dir_d = dir_q;
		if (wr_cnt) begin
			cnt_d = pwdata[15:0];
		end else if (sync_ld) begin
			cnt_d = phase_q;
			if (mode == PWTB_UPDOWN) begin
				dir_d = post_sync_direction;
			end
		end else if (step) begin
			case (mode)
				PWTB_UP: begin
					dir_d = 1'b1;
					cnt_d = at_prd ? 16'h0 : cnt_q + 16'h1;
				end
				PWTB_DOWN: begin
					dir_d = 1'b0;
					cnt_d = at_zero ? prd_act_q : cnt_q - 16'h1;
				end
				PWTB_UPDOWN: begin
					if (dir_q && at_prd) begin
						dir_d = 1'b0;
						cnt_d = cnt_q - 16'h1;
					end else if (!dir_q && at_zero) begin
						dir_d = 1'b1;
						cnt_d = cnt_q + 16'h1;
					end else begin
						cnt_d = dir_q ? cnt_q + 16'h1 : cnt_q - 16'h1;
					end
				end
				default: begin
					cnt_d = cnt_q;
				end
			endcase
		end
	end
	wire cnt_moved = wr_cnt | sync_ld | step;

	// Counter, direction and event strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0;
			dir_q <= 1'b1;
			zero_q <= 1'b0;
			prd_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			dir_q <= dir_d;
			zero_q <= cnt_moved && (cnt_d == 16'h0);
			prd_q <= cnt_moved && (cnt_d == prd_act_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Period: shadow or direct, shadow copied in while the count is zero
	wire shd_load = at_zero & ~period_load_select;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prd_act_q <= 16'h0;
			prd_shd_q <= 16'h0;
		end else begin
			if (wr_prd && !period_load_select) begin
				prd_shd_q <= pwdata[15:0];
			end
			if (wr_prd && period_load_select) begin
				prd_act_q <= pwdata[15:0];
			end else if (shd_load) begin
				prd_act_q <= prd_shd_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, phase and fine registers; software sync bit is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PWTB_CTRL_RESET;
			phase_q <= 16'h0;
			fine_q <= 16'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[15:0] & ~(16'h1 << `PWTB_F_SWSYNC);
			end
			if (wr & hit_phase) begin
				phase_q <= pwdata[15:0];
			end
			if (wr & hit_fine) begin
				fine_q <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status flags: a new event wins over a clear
	wire max_hit = (cnt_q == `PWTB_MAX_COUNT);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			max_q <= 1'b0;
			sync_seen_q <= 1'b0;
		end else begin
			max_q <= max_hit | (max_q & ~(wr_stat & pwdata[`PWTB_S_MAX]));
			sync_seen_q <= ext_sync | (sync_seen_q & ~(wr_stat & pwdata[`PWTB_S_SYNC]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync output select
	wire compare_b_value_hit = cnt_moved && (cnt_d == compare_b_value);
	wire sync_out_d = (sync_out_source == PWTB_SO_SYNCIN) ? sync_evt :
		(sync_out_source == PWTB_SO_ZERO) ? (cnt_moved && (cnt_d == 16'h0)) :
		(sync_out_source == PWTB_SO_COMPARE_B_VALUE) ? compare_b_value_hit : 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out_q <= 1'b0;
		end else begin
			sync_out_q <= sync_out_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux and APB answer, one wait state
	wire [15:0] prd_view = period_load_select ? prd_act_q : prd_shd_q;
	wire [15:0] stat_view = {13'h0, max_q, sync_seen_q, dir_q};
	wire [15:0] rd_mux = hit_ctrl ? ctrl_q :
		hit_stat ? stat_view :
		hit_fine ? fine_q :
		hit_phase ? phase_q :
		hit_count ? cnt_q :
		hit_prd ? prd_view : 16'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc & ~pready_q;
			pslverr_q <= acc & ~pready_q & ~mapped;
			prdata_q <= (acc & ~pready_q & ~pwrite) ? {16'h0, rd_mux} : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sync_out = sync_out_q;
	assign ctr_zero_evt = zero_q;
	assign ctr_prd_evt = prd_q;
	assign count_out = cnt_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_sync_load;
		sync_ld && !wr_cnt;
	endsequence
	sequence s_up_wrap;
		step && !wr_cnt && !sync_ld && mode == PWTB_UP && at_prd;
	endsequence
	// Steps of the debug halt behaviour
	sequence s_halt_step;
		emu_halt && emu == 2'h0 && step;
	endsequence
	sequence s_halt_end;
		emu_halt && emu == 2'h1 && cycle_end;
	endsequence

	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pready_q |=> pready_q)
		else $error("APB access not answered in one wait state");
	swsync_reads_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(acc && hit_ctrl && !pwrite && !pready_q) |-> !prdata_q[`PWTB_F_SWSYNC])
		else $error("software sync bit read back as one");
	phase_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_sync_load |=> cnt_q == $past(phase_q))
		else $error("counter not loaded with phase on sync");
	post_sync_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_sync_load ##0 mode == PWTB_UPDOWN |=> dir_q == $past(post_sync_direction))
		else $error("direction after sync wrong");
	up_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_up_wrap |=> cnt_q == 16'h0 && ctr_zero_evt)
		else $error("up count did not wrap to zero");
	max_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		max_hit |=> max_q)
		else $error("max flag not set at full count");
	syncout_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctr_zero_evt && $past(sync_out_source == PWTB_SO_ZERO) |-> sync_out)
		else $error("sync out missed zero event");
	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == PWTB_FREEZE && !wr_cnt && !sync_ld |=> $stable(cnt_q))
		else $error("frozen counter moved");
	emu_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_halt_step ##1 emu_halt && emu == 2'h0 |-> !step)
		else $error("counter kept stepping while halted");
	halt_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_halt_end |-> !step)
		else $error("counter stepped past the halt stop point");

	// Register updates and counting details
	cnt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cnt |=> cnt_q == $past(pwdata[15:0]))
		else $error("counter write did not land at once");
	period_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_prd && period_load_select |=> prd_act_q == $past(pwdata[15:0]))
		else $error("direct period write did not reach the active period");
	shadow_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		shd_load |=> prd_act_q == $past(prd_shd_q))
		else $error("shadow period not copied at zero");
	sync_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_sync |=> sync_seen_q)
		else $error("sync flag not set on external sync");
	up_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
		step && !wr_cnt && !sync_ld && mode == PWTB_UP |=> dir_q)
		else $error("direction bit not up while counting up");
	tick_space_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !wr_ctrl && div_w != 11'h1 |=> !tick)
		else $error("time-base ticks too close together");

endmodule : pwtb_top

//--- verif/pwtb_sync_peer.sv
// Neighbouring time-base modules: upstream sync source, downstream sync sink
`timescale 1ns/1ps
module pwtb_sync_peer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic fire,
	input wire logic [15:0] cmp_set,
	output int pulses,
	// Sync chain
	output logic sync_in,
	output logic [15:0] compare_b_value,
	input wire logic sync_out
);
	int hold;
	// Upstream pulse: two cycles high, then at least three low before the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_in <= 1'b0;
			hold <= 0;
		end else if (fire && hold == 0) begin
			sync_in <= 1'b1;
			hold <= 4;
		end else if (hold > 0) begin
			hold <= hold - 1;
			sync_in <= (hold > 3);
		end
	end
	// Downstream sink counts the pulses it receives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulses <= 0;
		end else if (sync_out) begin
			pulses <= pulses + 1;
		end
	end
	// Compare B of the neighbour follows the bench
	assign compare_b_value = cmp_set;
endmodule : pwtb_sync_peer

//--- verif/pwtb_top_test.sv
// Self-checking bench of the PWM time-base unit
`timescale 1ns/1ps
`include "pwtb_regs.svh"
module pwtb_top_test import pwtb_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, emu_halt, fire, err;
	logic sync_in, sync_out, ctr_zero_evt, ctr_prd_evt, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] cmp_set, count_out, compare_b_value;
	int error_cnt = 0, cmp_count = 0, zc = 0, pc = 0, pulses;
	////////////////////////////////////////////////////////////////
	pwtb_top #(.CNT_W(16), .HAS_FINE(1'b0)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_in(sync_in), .emu_halt(emu_halt),
		.compare_b_value(compare_b_value), .sync_out(sync_out), .ctr_zero_evt(ctr_zero_evt),
		.ctr_prd_evt(ctr_prd_evt), .count_out(count_out));
	pwtb_sync_peer peer (.pclk(pclk), .presetn(presetn), .fire(fire), .cmp_set(cmp_set),
		.pulses(pulses), .sync_in(sync_in), .compare_b_value(compare_b_value),
		.sync_out(sync_out));
	////////////////////////////////////////////////////////////////
	// Control word from its fields
	function automatic logic [15:0] ctl(int em, ls, hs, sw, so, pl, pe, md);
		return {em[1:0], 1'b0, ls[2:0], hs[2:0], sw[0], so[1:0], pl[0], pe[0], md[1:0]};
	endfunction : ctl
	function automatic int dv(int hs, int ls);
		return (hs == 0 ? 1 : 2 * hs) << ls;
	endfunction : dv
	function automatic logic [31:0] inr(int x, int lo, int hi);
		return {31'h0, x >= lo && x <= hi};
	endfunction : inr
	task automatic summarize();
		$display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [3:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			$display("Error at %0t: no pready", $time);
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [3:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d);
	endtask : wr
	task automatic rdc(input logic [3:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rd, {16'h0000, exp});
	endtask : rdc
	task automatic pulse();
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		cyc(8);
	endtask : pulse
	// Follows count_out for n cycles against the stepping model of mode md
	task automatic run(input int md, input logic [15:0] p, input int n);
		logic [15:0] pv, e;
		logic up;
		int ch, k;
		ch = 0;
		pv = count_out;
		up = (md != 1);
		for (k = 0; k < n; k++) begin
			@(posedge pclk);
			if (count_out !== pv) begin
				if (md == 2 && ch == 0 && pv != p && pv != 0)
					up = (count_out == pv + 16'h1);
				if (pv == p)
					up = 1'b0;
				if (pv == 0)
					up = 1'b1;
				e = md == 0 ? (pv == p ? 16'h0 : pv + 16'h1) : md == 1 ? (pv == 0 ? p : pv - 16'h1)
					: (up ? pv + 16'h1 : pv - 16'h1);
				chk({16'h0, count_out}, {16'h0, e});
				ch++;
				pv = count_out;
			end
		end
		chk({31'h0, ch > n / 2}, 32'h1);
	endtask : run
	always @(posedge pclk)
		if (ctr_zero_evt === 1'b1)
			zc++;
	always @(posedge pclk)
		if (ctr_prd_evt === 1'b1)
			pc++;
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Main sequence
	initial begin
		logic [15:0] p, ph, a, mx;
		int z0, q0, p0, hs, ls, k, n;
		{presetn, psel, penable, pwrite, emu_halt, fire} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		cmp_set = 16'h0000;
		void'($urandom(15));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`PWTB_IDX_CTRL, ctl(0, 0, 1, 0, 0, 0, 0, 3));
		rdc(`PWTB_IDX_STAT, 16'h0001);
		rdc(`PWTB_IDX_FINE, 16'h0000);
		chk({31'h0, err}, 32'h1);
		a = 16'($urandom);
		wr(`PWTB_IDX_COUNT, a);
		rdc(`PWTB_IDX_COUNT, a);
		$display("test reset_map done");
		p = 16'($urandom_range(20, 5));
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 3));
		wr(`PWTB_IDX_PERIOD, p);
		rdc(`PWTB_IDX_PERIOD, p);
		wr(`PWTB_IDX_COUNT, 16'h0000);
		z0 = zc;
		p0 = pc;
		for (k = 0; k < 3; k++) begin
			wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, k));
			if (k < 2)
				rdc(`PWTB_IDX_STAT, k == 0 ? 16'h1 : 16'h0);
			run(k, p, 4 * (p + 1));
		end
		chk(inr(zc - z0, 6, 99), 32'h1);
		chk(inr(pc - p0, 6, 99), 32'h1);
		$display("test modes done");
		wr(`PWTB_IDX_PERIOD, 16'hFFFF);
		wr(`PWTB_IDX_COUNT, 16'hFFF0);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 0));
		cyc(30);
		wr(`PWTB_IDX_STAT, 16'h0000);
		rdc(`PWTB_IDX_STAT, 16'h0005);
		wr(`PWTB_IDX_STAT, 16'h0004);
		rdc(`PWTB_IDX_STAT, 16'h0001);
		for (k = 0; k < 3; k++) begin
			hs = k == 0 ? 7 : $urandom_range(7, 0);
			ls = k == 0 ? 7 : $urandom_range(3, 0);
			wr(`PWTB_IDX_COUNT, 16'h0000);
			wr(`PWTB_IDX_CTRL, ctl(0, ls, hs, 0, 0, 1, 0, 0));
			apb(1'b0, `PWTB_IDX_COUNT, 16'h0);
			a = rd[15:0];
			// The two reads sample the count four cycles beyond the wait
			cyc(10 * dv(hs, ls) - 4);
			apb(1'b0, `PWTB_IDX_COUNT, 16'h0);
			chk(inr(rd[15:0] - a, 9, 11), 32'h1);
		end
		$display("test max_prescale done");
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 3));
		wr(`PWTB_IDX_PERIOD, 16'd100);
		wr(`PWTB_IDX_COUNT, 16'd40);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 0, 0, 0));
		wr(`PWTB_IDX_PERIOD, 16'd30);
		rdc(`PWTB_IDX_PERIOD, 16'd30);
		mx = 0;
		k = 0;
		do begin
			@(posedge pclk);
			mx = count_out > mx ? count_out : mx;
			k++;
		end while (count_out !== 16'h0 && k < 200);
		chk({31'h0, k < 200}, 32'h1);
		chk({16'h0, mx}, 32'd100);
		mx = 0;
		repeat (70) begin
			@(posedge pclk);
			mx = count_out > mx ? count_out : mx;
		end
		chk({16'h0, mx}, 32'd30);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 1, 3));
		rdc(`PWTB_IDX_PERIOD, 16'd30);
		$display("test shadow done");
		ph = 16'($urandom);
		wr(`PWTB_IDX_PHASE, ph);
		q0 = pulses;
		pulse();
		rdc(`PWTB_IDX_COUNT, ph);
		chk(pulses - q0, 32'd1);
		rdc(`PWTB_IDX_STAT, 16'h0003);
		wr(`PWTB_IDX_STAT, 16'h0002);
		rdc(`PWTB_IDX_STAT, 16'h0001);
		wr(`PWTB_IDX_COUNT, 16'h0000);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 1, 0, 1, 1, 3));
		rdc(`PWTB_IDX_COUNT, ph);
		rdc(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 1, 3));
		wr(`PWTB_IDX_COUNT, 16'h0000);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 3, 1, 1, 3));
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 1, 3, 1, 1, 3));
		rdc(`PWTB_IDX_COUNT, 16'h0000);
		q0 = pulses;
		pulse();
		chk(pulses - q0, 32'd0);
		a = ~ph;
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 3));
		wr(`PWTB_IDX_COUNT, a);
		pulse();
		rdc(`PWTB_IDX_COUNT, a);
		$display("test sync done");
		wr(`PWTB_IDX_PERIOD, 16'd9);
		wr(`PWTB_IDX_COUNT, 16'h0000);
		cmp_set <= 16'd4;
		for (k = 1; k < 3; k++) begin
			wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, k, 1, 0, 0));
			q0 = pulses;
			cyc(100);
			chk(inr(pulses - q0, 9, 11), 32'h1);
		end
		// Up-down: phase 200 lies outside the period, so the next step shows the direction
		for (k = 0; k < 2; k++) begin
			wr(`PWTB_IDX_COUNT, 16'h0000);
			wr(`PWTB_IDX_PHASE, 16'd200);
			wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 1, 2) | {2'h0, k[0], 13'h0});
			fire <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				fire <= 1'b0;
				n++;
			end while (count_out !== 16'd200 && n < 20);
			@(posedge pclk);
			chk({16'h0, count_out}, k == 1 ? 32'd201 : 32'd199);
			cyc(4);
		end
		wr(`PWTB_IDX_COUNT, 16'h0000);
		$display("test post_sync_dir done");
		emu_halt <= 1'b1;
		wr(`PWTB_IDX_CTRL, ctl(2, 0, 0, 0, 0, 1, 0, 0));
		run(0, 16'd9, 30);
		wr(`PWTB_IDX_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 0));
		apb(1'b0, `PWTB_IDX_COUNT, 16'h0);
		a = rd[15:0];
		cyc(10);
		rdc(`PWTB_IDX_COUNT, a);
		// A stop holds until the halt ends, so each code 1 case starts a fresh halt
		emu_halt <= 1'b0;
		wr(`PWTB_IDX_CTRL, ctl(1, 0, 0, 0, 0, 1, 0, 0));
		emu_halt <= 1'b1;
		cyc(30);
		rdc(`PWTB_IDX_COUNT, 16'd9);
		emu_halt <= 1'b0;
		wr(`PWTB_IDX_CTRL, ctl(1, 0, 0, 0, 0, 1, 0, 1));
		emu_halt <= 1'b1;
		cyc(30);
		rdc(`PWTB_IDX_COUNT, 16'd0);
		emu_halt <= 1'b0;
		$display("test syncout_halt done");
		summarize();
	end
endmodule : pwtb_top_test
